// file: hdl/prss_seq.sv
/*
  Reset release sequencer: optional power-on extension, then three windows.
  Assumes the reset request is already synchronous to clk.
*/
`include "prss_map.svh"
module prss_seq
  import prss_pkg::*;
#(
  parameter logic [31:0] POR_EXT_CYCLES = `PRSS_POR_EXT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests
  input wire logic rst_req,
  input wire logic por_req,
  // Phase
  output prss_seq_t phase,
  output logic seq_done
);

  typedef struct packed {
    prss_seq_t ph;
    logic [31:0] cnt;
  } prss_seq_state_t;

  prss_seq_state_t st_reg;
  prss_seq_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (por_req) begin
      st_next.ph = PRSS_EXTEND;
      st_next.cnt = 32'h0000_0000;
    end else if (rst_req) begin
      st_next.ph = PRSS_CLKINIT;
      st_next.cnt = 32'h0000_0000;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h0000_0001;
      unique case (st_reg.ph)
        PRSS_EXTEND: begin
          if (st_reg.cnt == POR_EXT_CYCLES - 32'h0000_0001) begin
            st_next.ph = PRSS_CLKINIT;
            st_next.cnt = 32'h0000_0000;
          end
        end
        PRSS_CLKINIT, PRSS_PERIPH, PRSS_CORE: begin
          if (st_reg.cnt[7:0] == `PRSS_WINDOW_CYCLES - 8'h01) begin
            st_next.cnt = 32'h0000_0000;
            st_next.ph = (st_reg.ph == PRSS_CLKINIT) ? PRSS_PERIPH :
                         (st_reg.ph == PRSS_PERIPH) ? PRSS_CORE : PRSS_DONE;
          end
        end
        PRSS_DONE: st_next.cnt = 32'h0000_0000;
        default: st_next.ph = PRSS_EXTEND;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{ph: PRSS_EXTEND, cnt: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase = st_reg.ph;
  assign seq_done = (st_reg.ph == PRSS_DONE);

endmodule

// file: hdl/prss_sync.sv
/*
  Two flip-flop synchroniser for asynchronous level inputs.
  Assumes the reset level of the output is the one given, inactive for all but por_n.
*/
module prss_sync
  import prss_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Level
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } prss_sync_state_t;

  prss_sync_state_t st_reg;
  prss_sync_state_t st_next;

  always_comb begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;

endmodule

// file: hdl/prss_top.sv
/*
  Power mode, reset and flash security control of the system integration
  module. Assumes pins are asynchronous; core and peripherals share clk.
*/
// Added by the designer: the plain strobed port and the address map.
// How it works
// - Run mode keeps core, memory and peripheral clocks running.
// - Wait mode stops core and memory clocks; peripherals keep running.
// - Unmasked peripheral interrupt ends Wait and resumes the core.
// - Stop ends only on CAN traffic, non-clocked interrupt, or resets.
// - Peripherals except watchdog use the peripheral bus clock, at most 60MHz.
// - Stop never powers down the PLL by itself; software does that.
// - Control register disables stop/wait, temporarily or until reset.
// - Four reset sources: pin and power-on async, software and watchdog sync.
// - Power-on reset adds 2^21 cycles of hold before the sequence.
// - Three 32-clock windows: clocking, peripherals/security, core, then run.
// - Reset release is synchronised to a rising system clock edge.
// - Two nonvolatile flash bytes set security, surviving reset and power loss.
// - Secured: block external program space, external boot, debug port.
// - Boot selects internal boot, external boot or secure mode.
// - Secured boot is internal, no external space, starts at 0x02_0000.
// - Secured device ignores the external boot select pin.
// - Chip JTAG TAP is active at boot regardless of security.
// - During reset the debug read disable follows the security bytes; here only in the PRSS_PERIPH phase, holding its value otherwise.
// - Security changes nothing else about normal execution.
`include "prss_map.svh"
module prss_top
  import prss_pkg::*;
#(
  parameter logic [31:0] POR_EXT_CYCLES = `PRSS_POR_EXT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Reset sources
  input wire logic reset_pin_n,
  input wire logic por_n,
  input wire logic watchdog_reset,
  // Wake sources
  input wire logic can_activity,
  input wire logic async_irq,
  input wire logic periph_irq,
  input wire logic periph_irq_masked,
  // Core requests
  input wire logic core_stop_req,
  input wire logic core_wait_req,
  // Boot and security
  input wire logic external_boot_select,
  input wire logic [7:0] sec_byte_lo,
  input wire logic [7:0] sec_byte_hi,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Clock, reset and security outputs
  output prss_clk_t clk_ctl,
  output prss_rst_t rst_ctl,
  output prss_sec_t sec_ctl,
  output prss_boot_t boot_mode,
  output prss_mode_t power_mode,
  output logic code_run,
  output logic can_first_msg_drop
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic reset_pin_n_s;
  logic por_n_s;
  logic ext_boot_s;
  logic can_s;
  logic async_irq_s;

  prss_sync #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk(clk), .srst(srst), .d(reset_pin_n), .q(reset_pin_n_s)
  );
  prss_sync #(.RESET_VAL(1'b0)) u_sync_por (
    .clk(clk), .srst(srst), .d(por_n), .q(por_n_s)
  );
  prss_sync #(.RESET_VAL(1'b0)) u_sync_boot (
    .clk(clk), .srst(srst), .d(external_boot_select), .q(ext_boot_s)
  );
  prss_sync #(.RESET_VAL(1'b0)) u_sync_can (
    .clk(clk), .srst(srst), .d(can_activity), .q(can_s)
  );
  prss_sync #(.RESET_VAL(1'b0)) u_sync_irq (
    .clk(clk), .srst(srst), .d(async_irq), .q(async_irq_s)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    prss_mode_t mode;
    logic [15:0] ctl;
    logic sw_rst;
    logic secured;
    prss_boot_t boot;
    logic [15:0] rdata;
    prss_clk_t clks;
    prss_rst_t rsts;
    prss_sec_t sec;
    logic run;
    logic can_drop;
    logic [1:0] last_cause;
  } prss_top_state_t;

  prss_top_state_t st_reg;
  prss_top_state_t st_next;

  prss_seq_t phase;
  logic seq_done;
  logic por_req;
  logic any_rst;
  logic sec_match;
  logic wait_ok;
  logic stop_ok;
  logic wake_stop;

  // Power-on and pin resets are async sources, software and watchdog sync
  assign por_req = ~por_n_s;
  assign any_rst = ~reset_pin_n_s | por_req | watchdog_reset | st_reg.sw_rst;

  prss_seq #(.POR_EXT_CYCLES(POR_EXT_CYCLES)) u_seq (
    .clk(clk),
    .srst(srst),
    .rst_req(any_rst),
    .por_req(por_req),
    .phase(phase),
    .seq_done(seq_done)
  );

  // Security from the two nonvolatile bytes; the flash keeps them
  assign sec_match = (sec_byte_lo == `PRSS_SEC_KEY_LO) &&
                     (sec_byte_hi == `PRSS_SEC_KEY_HI);

  assign wait_ok = ~st_reg.ctl[`PRSS_CTL_WAIT_DIS] & ~st_reg.ctl[`PRSS_CTL_PERM_WAIT];
  assign stop_ok = ~st_reg.ctl[`PRSS_CTL_STOP_DIS] & ~st_reg.ctl[`PRSS_CTL_PERM_STOP];
  assign wake_stop = can_s | async_irq_s;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sw_rst = 1'b0;
    st_next.can_drop = 1'b0;

    // Register writes
    if (reg_wr && reg_addr == `PRSS_OFS_CONTROL) begin
      // Permanent bits stay set until reset
      st_next.ctl = reg_wdata & 16'h0023;
      st_next.ctl[`PRSS_CTL_PERM_WAIT] = st_reg.ctl[`PRSS_CTL_PERM_WAIT] |
                                         reg_wdata[`PRSS_CTL_PERM_WAIT];
      st_next.ctl[`PRSS_CTL_PERM_STOP] = st_reg.ctl[`PRSS_CTL_PERM_STOP] |
                                         reg_wdata[`PRSS_CTL_PERM_STOP];
      st_next.ctl[`PRSS_CTL_SW_RESET] = 1'b0;
      st_next.sw_rst = reg_wdata[`PRSS_CTL_SW_RESET];
    end

    // Register reads
    st_next.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `PRSS_OFS_CONTROL: st_next.rdata = st_reg.ctl;
        `PRSS_OFS_STATUS: st_next.rdata = {5'h00, st_reg.last_cause, st_reg.secured,
                                           phase, st_reg.run, st_reg.mode, 2'b00};
        `PRSS_OFS_BOOT: st_next.rdata = {14'h0000, st_reg.boot};
        default: st_next.rdata = 16'h0000;
      endcase
    end

    // Power modes
    unique case (st_reg.mode)
      PRSS_RUN: begin
        if (st_reg.run && core_stop_req && stop_ok) begin
          st_next.mode = PRSS_STOP;
        end else if (st_reg.run && core_wait_req && wait_ok) begin
          st_next.mode = PRSS_WAIT;
        end
      end
      PRSS_WAIT: begin
        if (periph_irq && !periph_irq_masked) begin
          st_next.mode = PRSS_RUN;
        end
      end
      PRSS_STOP: begin
        if (wake_stop) begin
          st_next.mode = PRSS_RUN;
          st_next.can_drop = can_s;
        end
      end
      default: st_next.mode = PRSS_RUN;
    endcase

    // Clock gating; peripherals share the core clock domain
    st_next.clks.core_clk_en = (st_next.mode == PRSS_RUN);
    st_next.clks.mem_clk_en = (st_next.mode == PRSS_RUN);
    st_next.clks.periph_clk_en = (st_next.mode != PRSS_STOP);
    // PLL only follows software, never the mode
    st_next.clks.pll_power_down = st_next.ctl[`PRSS_CTL_PLL_OFF];

    // Reset release windows
    st_next.rsts.sim_rst = (phase == PRSS_EXTEND);
    st_next.rsts.periph_rst = (phase == PRSS_EXTEND) || (phase == PRSS_CLKINIT);
    st_next.rsts.core_rst = !(phase == PRSS_CORE || phase == PRSS_DONE);
    st_next.run = seq_done && !any_rst;

    // Boot mode and security latched while peripherals come out of reset
    if (phase == PRSS_PERIPH) begin
      st_next.secured = sec_match;
      if (sec_match) begin
        st_next.boot = PRSS_BOOT_SEC;
      end else if (ext_boot_s) begin
        st_next.boot = PRSS_BOOT_EXT;
      end else begin
        st_next.boot = PRSS_BOOT_INT;
      end
    end
    st_next.sec.ext_pspace_block = st_next.secured;
    st_next.sec.debug_read_dis = st_next.secured;
    st_next.sec.jtag_tap_en = 1'b1;
    // Secure boots internal flash; nothing else changes
    st_next.sec.boot_addr = (st_next.boot == PRSS_BOOT_EXT) ?
                            `PRSS_EXT_BOOT_ADDR : `PRSS_BOOT_FLASH_ADDR;

    // Any reset returns to Run
    if (any_rst) begin
      st_next.mode = PRSS_RUN;
      st_next.ctl = `PRSS_CTL_RESET;
      st_next.last_cause = por_req ? 2'd1 : (!reset_pin_n_s ? 2'd2 :
                           (watchdog_reset ? 2'd3 : 2'd0));
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg.mode <= PRSS_RUN;
      st_reg.ctl <= `PRSS_CTL_RESET;
      st_reg.sw_rst <= 1'b0;
      st_reg.secured <= 1'b1;
      st_reg.boot <= PRSS_BOOT_INT;
      st_reg.rdata <= 16'h0000;
      st_reg.clks <= '{core_clk_en: 1'b0, mem_clk_en: 1'b0, periph_clk_en: 1'b0,
                       pll_power_down: 1'b0};
      st_reg.rsts <= '{sim_rst: 1'b1, periph_rst: 1'b1, core_rst: 1'b1};
      st_reg.sec <= '{ext_pspace_block: 1'b1, debug_read_dis: 1'b1, jtag_tap_en: 1'b1,
                      boot_addr: `PRSS_BOOT_FLASH_ADDR};
      st_reg.run <= 1'b0;
      st_reg.can_drop <= 1'b0;
      st_reg.last_cause <= 2'd1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign clk_ctl = st_reg.clks;
  assign rst_ctl = st_reg.rsts;
  assign sec_ctl = st_reg.sec;
  assign boot_mode = st_reg.boot;
  assign power_mode = st_reg.mode;
  assign code_run = st_reg.run;
  assign can_first_msg_drop = st_reg.can_drop;

endmodule

// file: shared/prss_map.svh
/*
  Offsets, field positions, reset values and timing counts of the power, reset
  and security sequencer. Assumes a system clock of at most 60 MHz.
*/
`ifndef PRSS_MAP_SVH
`define PRSS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRSS_OFS_CONTROL 4'h0
`define PRSS_OFS_STATUS 4'h1
`define PRSS_OFS_BOOT 4'h2

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define PRSS_CTL_WAIT_DIS 0
`define PRSS_CTL_STOP_DIS 1
`define PRSS_CTL_PERM_WAIT 2
`define PRSS_CTL_PERM_STOP 3
`define PRSS_CTL_SW_RESET 4
`define PRSS_CTL_PLL_OFF 5
`define PRSS_CTL_RESET 16'h0000

// ----------------------------------------
// Security bytes and boot
// ----------------------------------------
`define PRSS_SEC_KEY_LO 8'h00
`define PRSS_SEC_KEY_HI 8'h00
`define PRSS_BOOT_FLASH_ADDR 24'h02_0000
`define PRSS_EXT_BOOT_ADDR 24'h00_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define PRSS_POR_EXT_CYCLES 32'h0020_0000
`define PRSS_WINDOW_CYCLES 8'h20
`define PRSS_MAX_SYS_MHZ 60

`endif

// file: shared/prss_pkg.sv
/*
  Types of the power, reset and security sequencer.
  Assumes prss_map.svh holds the numbers.
*/
package prss_pkg;

  typedef enum logic [1:0] {
    PRSS_RUN = 2'b00,
    PRSS_WAIT = 2'b01,
    PRSS_STOP = 2'b11
  } prss_mode_t;

  typedef enum logic [2:0] {
    PRSS_EXTEND = 3'b000,
    PRSS_CLKINIT = 3'b001,
    PRSS_PERIPH = 3'b011,
    PRSS_CORE = 3'b010,
    PRSS_DONE = 3'b110
  } prss_seq_t;

  typedef enum logic [1:0] {
    PRSS_BOOT_INT = 2'b00,
    PRSS_BOOT_EXT = 2'b01,
    PRSS_BOOT_SEC = 2'b10
  } prss_boot_t;

  typedef struct packed {
    logic core_clk_en;
    logic mem_clk_en;
    logic periph_clk_en;
    logic pll_power_down;
  } prss_clk_t;

  typedef struct packed {
    logic sim_rst;
    logic periph_rst;
    logic core_rst;
  } prss_rst_t;

  typedef struct packed {
    logic ext_pspace_block;
    logic debug_read_dis;
    logic jtag_tap_en;
    logic [23:0] boot_addr;
  } prss_sec_t;

endpackage

// file: verification/prss_chk.sv
/*
  Port checker of the power, reset and security sequencer.
  Assumes it is bound to prss_top and that srst resets everything.
*/
`include "prss_map.svh"
module prss_chk
  import prss_pkg::*;
(
  // Clock, reset and sources
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic por_n,
  input wire logic watchdog_reset,
  input wire logic can_activity,
  input wire logic async_irq,
  input wire logic periph_irq,
  input wire logic periph_irq_masked,
  input wire logic reg_wr,
  input wire logic [7:0] sec_byte_lo,
  input wire logic [7:0] sec_byte_hi,
  // Outputs
  input wire prss_clk_t clk_ctl,
  input wire prss_rst_t rst_ctl,
  input wire prss_sec_t sec_ctl,
  input wire prss_boot_t boot_mode,
  input wire prss_mode_t power_mode,
  input wire logic code_run
);
  logic [7:0] rel_reg;
  logic [7:0] rel_next;
  prss_rst_t rst_prev_reg;
  // Length of the current run of equal reset outputs, saturating
  always_comb begin
    rel_next = (rst_ctl == rst_prev_reg) ? rel_reg + 8'(rel_reg != 8'hFF) : 8'h01;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rel_reg <= 8'h00;
      rst_prev_reg <= 3'h7;
    end else begin
      rel_reg <= rel_next;
      rst_prev_reg <= rst_ctl;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_stop_quiet;
    power_mode == PRSS_STOP && !can_activity && !async_irq && reset_pin_n && por_n
      && !watchdog_reset && !reg_wr;
  endsequence
  sequence s_boot_done;
    $rose(code_run);
  endsequence
  property p_run_clk;
    (code_run && power_mode == PRSS_RUN)[*2] |->
      clk_ctl.core_clk_en && clk_ctl.mem_clk_en && clk_ctl.periph_clk_en;
  endproperty
  property p_wait_clk;
    (power_mode == PRSS_WAIT)[*2] |->
      !clk_ctl.core_clk_en && !clk_ctl.mem_clk_en && clk_ctl.periph_clk_en;
  endproperty
  property p_wait_exit;
    power_mode == PRSS_WAIT && periph_irq && !periph_irq_masked |=> power_mode == PRSS_RUN;
  endproperty
  property p_stop_hold;
    s_stop_quiet[*4] |=> power_mode == PRSS_STOP;
  endproperty
  property p_pll;
    power_mode != PRSS_STOP ##1 power_mode == PRSS_STOP |-> $stable(clk_ctl.pll_power_down);
  endproperty
  property p_periph_win;
    $fell(rst_ctl.periph_rst) |-> rst_prev_reg == 3'h3 && rel_reg >= `PRSS_WINDOW_CYCLES;
  endproperty
  property p_core_win;
    $fell(rst_ctl.core_rst) |-> !rst_ctl.periph_rst && rst_prev_reg == 3'h1 &&
      rel_reg >= `PRSS_WINDOW_CYCLES;
  endproperty
  property p_run_rel;
    s_boot_done |-> rst_ctl == 3'b000;
  endproperty
  property p_pin;
    $fell(reset_pin_n) |-> ##[1:5] rst_ctl.core_rst;
  endproperty
  property p_sec;
    s_boot_done |-> (boot_mode == PRSS_BOOT_SEC) ==
      (sec_byte_lo == `PRSS_SEC_KEY_LO && sec_byte_hi == `PRSS_SEC_KEY_HI);
  endproperty
  property p_tap;
    s_boot_done |-> sec_ctl.jtag_tap_en && sec_ctl.debug_read_dis == sec_ctl.ext_pspace_block
      && sec_ctl.debug_read_dis == (boot_mode == PRSS_BOOT_SEC);
  endproperty
  property p_boot_addr;
    s_boot_done |-> boot_mode != PRSS_BOOT_SEC || sec_ctl.boot_addr == `PRSS_BOOT_FLASH_ADDR;
  endproperty
  a_run_clk: assert property (p_run_clk) else $error("clocks off in run");
  a_wait_clk: assert property (p_wait_clk) else $error("wrong clocks in wait");
  a_wait_exit: assert property (p_wait_exit) else $error("wait not ended");
  a_stop_hold: assert property (p_stop_hold) else $error("stop left unasked");
  a_pll: assert property (p_pll) else $error("stop moved pll");
  a_periph_win: assert property (p_periph_win) else $error("periph early");
  a_core_win: assert property (p_core_win) else $error("core early");
  a_run_rel: assert property (p_run_rel) else $error("run in reset");
  a_pin: assert property (p_pin) else $error("pin reset missed");
  a_sec: assert property (p_sec) else $error("boot mode wrong");
  a_tap: assert property (p_tap) else $error("debug state wrong");
  a_boot_addr: assert property (p_boot_addr) else $error("boot address wrong");
endmodule
bind prss_top prss_chk u_chk (.clk, .srst, .reset_pin_n, .por_n, .watchdog_reset,
  .can_activity, .async_irq, .periph_irq, .periph_irq_masked, .reg_wr, .sec_byte_lo,
  .sec_byte_hi, .clk_ctl, .rst_ctl, .sec_ctl, .boot_mode, .power_mode, .code_run);

// file: verification/prss_core_model.sv
/*
  Stand-in for the core and a peripheral.
  Assumes bench commands are one-cycle pulses, cmd_irq a level.
*/
module prss_core_model
  import prss_pkg::*;
(
  // Clock and commands
  input wire logic clk,
  input wire logic cmd_wait,
  input wire logic cmd_stop,
  input wire logic cmd_irq,
  // Sequencer view
  input wire prss_clk_t clk_ctl,
  input wire logic code_run,
  // Core side
  output logic core_wait_req,
  output logic core_stop_req,
  output logic periph_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic live;
  assign live = code_run && clk_ctl.core_clk_en;
  always @(posedge clk) begin
    core_wait_req <= cmd_wait && live;
    core_stop_req <= cmd_stop && live;
    // Peripheral runs only on its bus clock
    periph_irq <= cmd_irq && clk_ctl.periph_clk_en;
  end
endmodule

// file: verification/prss_tb.sv
/*
  Register-task testbench of the sequencer.
  Assumes prss_top with a shortened power-on extension.
*/
`include "prss_map.svh"
module testbench
  import prss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst, reset_pin_n, por_n, watchdog_reset, can_activity, async_irq;
  logic periph_irq, periph_irq_masked, core_stop_req, core_wait_req, external_boot_select;
  logic [7:0] sec_byte_lo, sec_byte_hi;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, code_run, can_first_msg_drop, cmd_wait, cmd_stop, cmd_irq;
  prss_clk_t clk_ctl;
  prss_rst_t rst_ctl;
  prss_sec_t sec_ctl;
  prss_boot_t boot_mode;
  prss_mode_t power_mode;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, n_pin;
  always #2 clk = ~clk;
  prss_top #(.POR_EXT_CYCLES(32'h0000_0040)) dut (.clk, .srst, .reset_pin_n, .por_n,
    .watchdog_reset, .can_activity, .async_irq, .periph_irq, .periph_irq_masked,
    .core_stop_req, .core_wait_req, .external_boot_select, .sec_byte_lo, .sec_byte_hi,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clk_ctl, .rst_ctl, .sec_ctl,
    .boot_mode, .power_mode, .code_run, .can_first_msg_drop);
  prss_core_model core (.clk, .cmd_wait, .cmd_stop, .cmd_irq, .clk_ctl, .code_run,
    .core_wait_req, .core_stop_req, .periph_irq);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic core_cmd(input logic w);
    @(posedge clk) {cmd_wait, cmd_stop} <= w ? 2'b10 : 2'b01;
    @(posedge clk) {cmd_wait, cmd_stop} <= 2'b00;
    cycles(4);
  endtask
  task automatic wait_run(output int c);
    c = 0;
    while (code_run !== 1'b1 && c < 3000) begin
      cycles(1);
      c++;
    end
    chk(32'(code_run), 32'h0000_0001);
    cycles(1);
  endtask
  task automatic wake(input logic can);
    @(posedge clk) {can_activity, async_irq} <= can ? 2'b10 : 2'b01;
    cycles(6);
    chk(32'(power_mode), 32'(PRSS_RUN));
    @(posedge clk) {can_activity, async_irq} <= 2'b00;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {srst, reset_pin_n, por_n, external_boot_select} = 4'b1111;
    {watchdog_reset, can_activity, async_irq, periph_irq_masked} = 4'b0000;
    {reg_wr, reg_rd, cmd_wait, cmd_stop, cmd_irq} = 5'b00000;
    {sec_byte_lo, sec_byte_hi} = 16'h0000;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    wait_run(n);
    chk(32'(boot_mode), 32'(PRSS_BOOT_SEC));
    chk(32'(sec_ctl), 32'h0702_0000);
    rd(4'hF, d);
    chk(32'(d), 32'h0000_0000);
    chk(32'(clk_ctl), 32'h0000_000E);
    @(posedge clk) periph_irq_masked <= 1'b1;
    core_cmd(1'b1);
    chk(32'(clk_ctl), 32'h0000_0002);
    @(posedge clk) cmd_irq <= 1'b1;
    cycles(4);
    chk(32'(power_mode), 32'(PRSS_WAIT));
    @(posedge clk) periph_irq_masked <= 1'b0;
    cycles(4);
    chk(32'(power_mode), 32'(PRSS_RUN));
    @(posedge clk) cmd_irq <= 1'b0;
    core_cmd(1'b0);
    cycles(20);
    chk(32'(power_mode), 32'(PRSS_STOP));
    wake(1'b0);
    core_cmd(1'b0);
    @(posedge clk) can_activity <= 1'b1;
    n = 0;
    while (can_first_msg_drop !== 1'b1 && n < 10) begin
      cycles(1);
      n++;
    end
    chk(32'(n < 10), 32'h0000_0001);
    wake(1'b1);
    wr(4'h0, 16'h0020);
    core_cmd(1'b0);
    chk(32'(clk_ctl.pll_power_down), 32'h0000_0001);
    wake(1'b0);
    wr(4'h0, 16'h0001);
    core_cmd(1'b1);
    chk(32'(power_mode), 32'(PRSS_RUN));
    wr(4'h0, 16'h0008);
    wr(4'h0, 16'h0000);
    rd(4'h0, d);
    chk(32'(d), 32'h0000_0008);
    core_cmd(1'b0);
    chk(32'(power_mode), 32'(PRSS_RUN));
    wr(4'h0, 16'h0010);
    cycles(2);
    chk(32'(rst_ctl.core_rst), 32'h0000_0001);
    cycles(8);
    wait_run(n);
    rd(4'h0, d);
    chk(32'(d), 32'h0000_0000);
    rd(4'h1, d);
    chk(32'(d[10:9]), 32'h0000_0000);
    @(posedge clk) {sec_byte_lo, sec_byte_hi} <= 16'hA55A;
    @(posedge clk) reset_pin_n <= 1'b0;
    cycles(4);
    @(posedge clk) reset_pin_n <= 1'b1;
    cycles(8);
    wait_run(n_pin);
    chk(32'(n_pin >= 80), 32'h0000_0001);
    chk(32'(boot_mode), 32'(PRSS_BOOT_EXT));
    chk(32'(sec_ctl), 32'h0100_0000);
    rd(4'h1, d);
    chk(32'(d[10:9]), 32'h0000_0002);
    @(posedge clk) reset_pin_n <= 1'b0;
    external_boot_select <= 1'b0;
    cycles(4);
    @(posedge clk) reset_pin_n <= 1'b1;
    cycles(50);
    @(posedge clk) watchdog_reset <= 1'b1;
    @(posedge clk) watchdog_reset <= 1'b0;
    cycles(8);
    wait_run(n);
    chk(32'(n >= 80), 32'h0000_0001);
    rd(4'h1, d);
    chk(32'(d[10:9]), 32'h0000_0003);
    chk(32'(boot_mode), 32'(PRSS_BOOT_INT));
    chk(32'(sec_ctl), 32'h0102_0000);
    @(posedge clk) {sec_byte_lo, sec_byte_hi} <= 16'h0000;
    external_boot_select <= 1'b1;
    @(posedge clk) por_n <= 1'b0;
    cycles(4);
    @(posedge clk) por_n <= 1'b1;
    cycles(8);
    wait_run(n);
    chk(32'(n >= n_pin + 48), 32'h0000_0001);
    chk(32'(boot_mode), 32'(PRSS_BOOT_SEC));
    rd(4'h1, d);
    chk(32'(d[10:9]), 32'h0000_0001);
    tally_and_finish();
  end
endmodule
